// ==== bal_pkg.sv ====
`default_nettype none

package bal_pkg;

  // ---------------------------------------------------------------
  // widths and constants
  // ---------------------------------------------------------------
  localparam int unsigned BAL_DATA_W   = 8;
  localparam int unsigned BAL_WIMM_W   = 6;
  localparam int unsigned BAL_WIDE_W   = 16;
  localparam logic [7:0]  BAL_ZERO     = 8'h00;
  localparam logic [7:0]  BAL_ALL_ONES = 8'hFF;
  localparam logic [7:0]  BAL_ONE      = 8'h01;
  localparam logic [7:0]  BAL_SIGN_MIN = 8'h80;
  localparam logic [7:0]  BAL_SIGN_MAX = 8'h7F;
  localparam logic [15:0] BAL_WZERO    = 16'h0000;
  localparam logic [1:0]  BAL_WIMM_PAD = 2'h0;

  // cycles from presenting the request to the done pulse
  localparam int unsigned BAL_SHORT_CYCLES = 1;
  localparam int unsigned BAL_WORD_CYCLES  = 2;

  // ---------------------------------------------------------------
  // operation codes and sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    BAL_ADD,
    BAL_ADD_CARRY,
    BAL_WORD_ADD_IMMEDIATE,
    BAL_SUBTRACT,
    BAL_SUBTRACT_CONSTANT,
    BAL_SUBTRACT_WITH_BORROW,
    BAL_SUBTRACT_CONSTANT_WITH_BORROW,
    BAL_WORD_SUBTRACT_IMMEDIATE,
    BAL_AND,
    BAL_AND_WITH_CONSTANT,
    BAL_OR,
    BAL_OR_WITH_CONSTANT,
    BAL_EXCLUSIVE_OR,
    BAL_COMPLEMENT,
    BAL_SIGN_FLIP,
    BAL_SET_BITS_BY_MASK,
    BAL_CLEAR_BITS_BY_MASK,
    BAL_PLUS_ONE,
    BAL_MINUS_ONE,
    BAL_TEST_ZERO_NEGATIVE,
    BAL_CLEAR_REGISTER,
    BAL_FILL_ALL_ONES
  } bal_op_t;

  typedef enum logic [0:0] {
    BAL_IDLE,
    BAL_WORD_HIGH
  } bal_state_t;

endpackage

`default_nettype wire

// ==== bal_byte_arith_logic_unit.sv ====
`timescale 1ns/1ps
`default_nettype none

// Operation
// - add and add-with-carry put dest plus source (plus carry) in dest, set Z C N V H, one cycle.
// - word add immediate adds a 6-bit constant to the high:low pair, sets Z C N V S, two cycles.
// - word subtract immediate takes a 6-bit constant from the pair, sets Z C N V S, two cycles.
// - subtract of a register or constant from dest stores the difference, sets Z C N V H, one cycle.
// - subtract with borrow stores dest minus source minus carry, sets Z C N V H, one cycle.
// - subtract constant with borrow stores dest minus constant minus carry, sets Z C N V H, one cycle.
// - AND with a register or constant stores the result and sets only Z N V, one cycle.
// - OR with register or constant and exclusive OR store the result, set only Z N V, one cycle.
// - set bits by mask ORs the mask into dest and sets Z N V in one cycle.
// - clear bits by mask ANDs dest with 0xFF minus the mask and sets Z N V in one cycle.
// - test leaves dest unchanged and sets Z N V from it in one cycle.
module bal_byte_arith_logic_unit
  import bal_pkg::*;
(
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      reset,
  // operation request
  input  wire logic                      op_start,
  input  wire bal_pkg::bal_op_t          op_code,
  input  wire logic [bal_pkg::BAL_DATA_W-1:0] dest_reg,
  input  wire logic [bal_pkg::BAL_DATA_W-1:0] source_reg,
  input  wire logic [bal_pkg::BAL_DATA_W-1:0] imm_value,
  input  wire logic [bal_pkg::BAL_DATA_W-1:0] pair_high,
  input  wire logic [bal_pkg::BAL_WIMM_W-1:0] word_imm,
  // results
  output logic [bal_pkg::BAL_DATA_W-1:0] result_r,
  output logic [bal_pkg::BAL_DATA_W-1:0] result_high_r,
  output logic                           done_r,
  output logic                           busy_r,
  // status flags
  output logic                           flag_c_r,
  output logic                           flag_z_r,
  output logic                           flag_n_r,
  output logic                           flag_v_r,
  output logic                           flag_s_r,
  output logic                           flag_h_r
);
  import bal_pkg::*;

  // -----------------------------------------------------------------
  // adder helpers: {carry, half, overflow, result}
  // -----------------------------------------------------------------
  function automatic logic [10:0] bal_add8(input logic [7:0] x,
                                           input logic [7:0] y,
                                           input logic       ci);
    logic [8:0] w;
    w = {1'h0, x} + {1'h0, y} + {8'h00, ci};
    return {w[8], x[4] ^ y[4] ^ w[4], (x[7] == y[7]) && (w[7] != x[7]),
            w[7:0]};
  endfunction

  function automatic logic [10:0] bal_sub8(input logic [7:0] x,
                                           input logic [7:0] y,
                                           input logic       ci);
    logic [8:0] w;
    w = {1'h0, x} - {1'h0, y} - {8'h00, ci};
    return {w[8], x[4] ^ y[4] ^ w[4], (x[7] != y[7]) && (w[7] != x[7]),
            w[7:0]};
  endfunction

  // -----------------------------------------------------------------
  // request decode
  // -----------------------------------------------------------------
  bal_state_t  state_r;
  logic        take;
  logic        word_op;
  logic        word_sub;
  logic [7:0]  pair_hi_r;
  logic [7:0]  wlo_r;
  logic        wcarry_r;
  logic        wsub_r;
  logic [10:0] wlo_nxt;
  logic [10:0] whi_nxt;
  logic [15:0] wide_nxt;

  assign take     = op_start && (state_r == BAL_IDLE);
  assign word_sub = (op_code == BAL_WORD_SUBTRACT_IMMEDIATE);
  assign word_op  = (op_code == BAL_WORD_ADD_IMMEDIATE) || word_sub;

  // -----------------------------------------------------------------
  // byte datapath
  // -----------------------------------------------------------------
  logic [10:0] arith;
  logic        is_arith;
  logic [7:0]  byte_nxt;
  logic        c_nxt;
  logic        z_nxt;
  logic        n_nxt;
  logic        v_nxt;
  logic        h_nxt;

  always_comb
  begin
    arith    = 11'h000;
    is_arith = 1'b0;
    byte_nxt = dest_reg;
    c_nxt    = flag_c_r;
    h_nxt    = flag_h_r;
    v_nxt    = 1'b0;
    case (op_code)
      BAL_ADD, BAL_ADD_CARRY:
      begin
        is_arith = 1'b1;
        arith = bal_add8(dest_reg, source_reg,
                         (op_code == BAL_ADD_CARRY) && flag_c_r);
      end
      BAL_SUBTRACT:
      begin
        is_arith = 1'b1;
        arith = bal_sub8(dest_reg, source_reg, 1'b0);
      end
      BAL_SUBTRACT_CONSTANT:
      begin
        is_arith = 1'b1;
        arith = bal_sub8(dest_reg, imm_value, 1'b0);
      end
      BAL_SUBTRACT_WITH_BORROW:
      begin
        is_arith = 1'b1;
        arith = bal_sub8(dest_reg, source_reg, flag_c_r);
      end
      BAL_SUBTRACT_CONSTANT_WITH_BORROW:
      begin
        is_arith = 1'b1;
        arith = bal_sub8(dest_reg, imm_value, flag_c_r);
      end
      BAL_SIGN_FLIP:
      begin
        is_arith = 1'b1;
        arith = bal_sub8(BAL_ZERO, dest_reg, 1'b0);
      end
      BAL_AND:                byte_nxt = dest_reg & source_reg;
      BAL_AND_WITH_CONSTANT:  byte_nxt = dest_reg & imm_value;
      BAL_OR:                 byte_nxt = dest_reg | source_reg;
      BAL_OR_WITH_CONSTANT:   byte_nxt = dest_reg | imm_value;
      BAL_EXCLUSIVE_OR:       byte_nxt = dest_reg ^ source_reg;
      BAL_SET_BITS_BY_MASK:   byte_nxt = dest_reg | imm_value;
      BAL_CLEAR_BITS_BY_MASK:
        byte_nxt = dest_reg & (BAL_ALL_ONES - imm_value);
      BAL_TEST_ZERO_NEGATIVE: byte_nxt = dest_reg & dest_reg;
      BAL_CLEAR_REGISTER:     byte_nxt = dest_reg ^ dest_reg;
      BAL_COMPLEMENT:
      begin
        byte_nxt = BAL_ALL_ONES - dest_reg;
        c_nxt    = 1'b1;
      end
      BAL_PLUS_ONE:
      begin
        byte_nxt = dest_reg + BAL_ONE;
        v_nxt    = (byte_nxt == BAL_SIGN_MIN);
      end
      BAL_MINUS_ONE:
      begin
        byte_nxt = dest_reg - BAL_ONE;
        v_nxt    = (byte_nxt == BAL_SIGN_MAX);
      end
      BAL_FILL_ALL_ONES:      byte_nxt = BAL_ALL_ONES;
      default:                byte_nxt = dest_reg;
    endcase
    if (is_arith)
    begin
      byte_nxt = arith[7:0];
      c_nxt    = arith[10];
      h_nxt    = arith[9];
      v_nxt    = arith[8];
    end
    z_nxt = (byte_nxt == BAL_ZERO);
    n_nxt = byte_nxt[7];
  end

  // -----------------------------------------------------------------
  // word datapath: low byte on the taking edge, high byte next
  // -----------------------------------------------------------------
  always_comb
  begin
    wlo_nxt = word_sub ? bal_sub8(dest_reg, {BAL_WIMM_PAD, word_imm}, 1'b0)
                       : bal_add8(dest_reg, {BAL_WIMM_PAD, word_imm}, 1'b0);
    whi_nxt = wsub_r ? bal_sub8(pair_hi_r, BAL_ZERO, wcarry_r)
                     : bal_add8(pair_hi_r, BAL_ZERO, wcarry_r);
    wide_nxt = {whi_nxt[7:0], wlo_r};
  end

  // -----------------------------------------------------------------
  // sequencer and word operand capture
  // -----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_r   <= BAL_IDLE;
      busy_r    <= 1'b0;
      pair_hi_r <= BAL_ZERO;
      wlo_r     <= BAL_ZERO;
      wcarry_r  <= 1'b0;
      wsub_r    <= 1'b0;
    end
    else
    begin
      case (state_r)
        BAL_IDLE:
          if (take && word_op)
          begin
            state_r   <= BAL_WORD_HIGH;
            busy_r    <= 1'b1;
            pair_hi_r <= pair_high;
            wlo_r     <= wlo_nxt[7:0];
            wcarry_r  <= wlo_nxt[10];
            wsub_r    <= word_sub;
          end
        BAL_WORD_HIGH:
        begin
          state_r <= BAL_IDLE;
          busy_r  <= 1'b0;
        end
        default:
        begin
          state_r <= BAL_IDLE;
          busy_r  <= 1'b0;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // results and completion
  // -----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      result_r      <= BAL_ZERO;
      result_high_r <= BAL_ZERO;
      done_r        <= 1'b0;
    end
    else if (state_r == BAL_WORD_HIGH)
    begin
      result_r      <= wide_nxt[7:0];
      result_high_r <= wide_nxt[15:8];
      done_r        <= 1'b1;
    end
    else
    begin
      done_r <= take && !word_op;
      if (take && !word_op)
        result_r <= byte_nxt;
    end
  end

  // -----------------------------------------------------------------
  // status flags
  // -----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      flag_c_r <= 1'b0;
      flag_z_r <= 1'b0;
      flag_n_r <= 1'b0;
      flag_v_r <= 1'b0;
      flag_s_r <= 1'b0;
      flag_h_r <= 1'b0;
    end
    else if (state_r == BAL_WORD_HIGH)
    begin
      flag_c_r <= whi_nxt[10];
      flag_v_r <= whi_nxt[8];
      flag_n_r <= wide_nxt[15];
      flag_z_r <= (wide_nxt == BAL_WZERO);
      flag_s_r <= wide_nxt[15] ^ whi_nxt[8];
    end
    else if (take && !word_op && (op_code != BAL_FILL_ALL_ONES))
    begin
      flag_c_r <= c_nxt;
      flag_z_r <= z_nxt;
      flag_n_r <= n_nxt;
      flag_v_r <= v_nxt;
      flag_h_r <= h_nxt;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking bal_cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence seq_word_add;
    take && (op_code == BAL_WORD_ADD_IMMEDIATE);
  endsequence

  sequence seq_word_sub;
    take && (op_code == BAL_WORD_SUBTRACT_IMMEDIATE);
  endsequence

  sequence seq_word_wait;
    busy_r && !done_r;
  endsequence

  AST_ADD_CARRY: assert property (
    take && (op_code == BAL_ADD_CARRY) |=> done_r &&
      (result_r == 8'($past(dest_reg) + $past(source_reg) +
                      {7'h00, $past(flag_c_r)})) &&
      (flag_z_r == (result_r == BAL_ZERO)))
    else $error("add with carry result or zero flag wrong");

  AST_WORD_ADD: assert property (
    seq_word_add |-> ##1 seq_word_wait ##1 (done_r &&
      ({result_high_r, result_r} == 16'({$past(pair_high, 2),
        $past(dest_reg, 2)} + {10'h000, $past(word_imm, 2)})) &&
      (flag_s_r == (flag_n_r ^ flag_v_r))))
    else $error("word add result or timing wrong");

  AST_WORD_SUB: assert property (
    seq_word_sub |-> ##1 seq_word_wait ##1 (done_r &&
      ({result_high_r, result_r} == 16'({$past(pair_high, 2),
        $past(dest_reg, 2)} - {10'h000, $past(word_imm, 2)})) &&
      (flag_c_r == ({10'h000, $past(word_imm, 2)} >
                    {$past(pair_high, 2), $past(dest_reg, 2)}))))
    else $error("word subtract result, borrow or timing wrong");

  AST_SUB_CONST: assert property (
    take && (op_code == BAL_SUBTRACT_CONSTANT) |=> done_r &&
      (result_r == 8'($past(dest_reg) - $past(imm_value))) &&
      (flag_c_r == ($past(imm_value) > $past(dest_reg))))
    else $error("subtract constant result or borrow wrong");

  AST_SUB_BORROW: assert property (
    take && (op_code == BAL_SUBTRACT_WITH_BORROW) |=>
      result_r == 8'($past(dest_reg) - $past(source_reg) -
                     {7'h00, $past(flag_c_r)}))
    else $error("subtract with borrow result wrong");

  AST_SUB_CONST_BORROW: assert property (
    take && (op_code == BAL_SUBTRACT_CONSTANT_WITH_BORROW) |=>
      result_r == 8'($past(dest_reg) - $past(imm_value) -
                     {7'h00, $past(flag_c_r)}))
    else $error("subtract constant with borrow result wrong");

  AST_AND_CONST: assert property (
    take && (op_code == BAL_AND_WITH_CONSTANT) |=>
      (result_r == ($past(dest_reg) & $past(imm_value))) && !flag_v_r &&
      (flag_c_r == $past(flag_c_r)) && (flag_h_r == $past(flag_h_r)))
    else $error("and with constant result or flags wrong");

  AST_XOR: assert property (
    take && (op_code == BAL_EXCLUSIVE_OR) |=>
      (result_r == ($past(dest_reg) ^ $past(source_reg))) &&
      (flag_c_r == $past(flag_c_r)) && (flag_n_r == result_r[7]))
    else $error("exclusive or result or flags wrong");

  AST_SET_BITS: assert property (
    take && (op_code == BAL_SET_BITS_BY_MASK) |=> done_r &&
      (result_r == ($past(dest_reg) | $past(imm_value))))
    else $error("set bits by mask result wrong");

  AST_CLEAR_BITS: assert property (
    take && (op_code == BAL_CLEAR_BITS_BY_MASK) |=>
      (result_r == ($past(dest_reg) & ~$past(imm_value))) &&
      (flag_z_r == (result_r == BAL_ZERO)))
    else $error("clear bits by mask result wrong");

  AST_TEST: assert property (
    take && (op_code == BAL_TEST_ZERO_NEGATIVE) |=>
      (result_r == $past(dest_reg)) && !flag_v_r &&
      (flag_z_r == ($past(dest_reg) == BAL_ZERO)))
    else $error("test result or flags wrong");

  AST_COMPLEMENT: assert property (
    take && (op_code == BAL_COMPLEMENT) |=> done_r && flag_c_r &&
      (result_r == ~$past(dest_reg)) && !flag_v_r &&
      (flag_n_r == result_r[7]) && (flag_h_r == $past(flag_h_r)))
    else $error("complement result or carry wrong");

endmodule

`default_nettype wire

// ==== bal_byte_arith_logic_unit_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module bal_byte_arith_logic_unit_tb_top;
  import bal_pkg::*;

  // ---------------------------------------------------------------
  // signals and expectations
  // ---------------------------------------------------------------
  typedef struct {
    bal_op_t    op;
    logic [7:0] d;
    logic [7:0] s;
    logic [7:0] k;
    logic [7:0] hi;
    logic [5:0] w;
    logic [7:0] res;
  } bal_row_t;

  logic       clock;
  logic       reset;
  logic       op_start;
  bal_op_t    op_code;
  logic [7:0] dest_reg;
  logic [7:0] source_reg;
  logic [7:0] imm_value;
  logic [7:0] pair_high;
  logic [5:0] word_imm;
  logic [7:0] result_r;
  logic [7:0] result_high_r;
  logic       done_r;
  logic       busy_r;
  logic       flag_c_r;
  logic       flag_z_r;
  logic       flag_n_r;
  logic       flag_v_r;
  logic       flag_s_r;
  logic       flag_h_r;
  int         err_count;
  int         samples_checked;
  logic [7:0] exp_lo;
  logic [7:0] exp_hi;
  logic [5:0] exp_f;
  logic [5:0] flags;

  assign flags = {flag_c_r, flag_z_r, flag_n_r, flag_v_r, flag_s_r, flag_h_r};

  // ordinary cases; carry in comes from the row before
  bal_row_t rows [22] = '{
    '{BAL_ADD,                           8'h3A, 8'hC6, 8'h00, 8'h00, 6'h00, 8'h00},
    '{BAL_ADD_CARRY,                     8'h0F, 8'h00, 8'h00, 8'h00, 6'h00, 8'h10},
    '{BAL_SUBTRACT,                      8'h10, 8'h20, 8'h00, 8'h00, 6'h00, 8'hF0},
    '{BAL_SUBTRACT_WITH_BORROW,          8'h50, 8'h10, 8'h00, 8'h00, 6'h00, 8'h3F},
    '{BAL_SUBTRACT_CONSTANT,             8'h80, 8'h00, 8'h01, 8'h00, 6'h00, 8'h7F},
    '{BAL_SUBTRACT_CONSTANT_WITH_BORROW, 8'h00, 8'h00, 8'hFF, 8'h00, 6'h00, 8'h01},
    '{BAL_AND,                           8'hF0, 8'h3C, 8'h00, 8'h00, 6'h00, 8'h30},
    '{BAL_AND_WITH_CONSTANT,             8'hAA, 8'h00, 8'h55, 8'h00, 6'h00, 8'h00},
    '{BAL_OR,                            8'h0F, 8'h80, 8'h00, 8'h00, 6'h00, 8'h8F},
    '{BAL_OR_WITH_CONSTANT,              8'h00, 8'h00, 8'h00, 8'h00, 6'h00, 8'h00},
    '{BAL_EXCLUSIVE_OR,                  8'hFF, 8'h0F, 8'h00, 8'h00, 6'h00, 8'hF0},
    '{BAL_COMPLEMENT,                    8'h5A, 8'h00, 8'h00, 8'h00, 6'h00, 8'hA5},
    '{BAL_SIGN_FLIP,                     8'h80, 8'h00, 8'h00, 8'h00, 6'h00, 8'h80},
    '{BAL_SET_BITS_BY_MASK,              8'h01, 8'h00, 8'h80, 8'h00, 6'h00, 8'h81},
    '{BAL_CLEAR_BITS_BY_MASK,            8'hFF, 8'h00, 8'h0F, 8'h00, 6'h00, 8'hF0},
    '{BAL_PLUS_ONE,                      8'h7F, 8'h00, 8'h00, 8'h00, 6'h00, 8'h80},
    '{BAL_MINUS_ONE,                     8'h80, 8'h00, 8'h00, 8'h00, 6'h00, 8'h7F},
    '{BAL_TEST_ZERO_NEGATIVE,            8'h00, 8'h00, 8'h00, 8'h00, 6'h00, 8'h00},
    '{BAL_CLEAR_REGISTER,                8'h77, 8'h00, 8'h00, 8'h00, 6'h00, 8'h00},
    '{BAL_FILL_ALL_ONES,                 8'h12, 8'h00, 8'h00, 8'h00, 6'h00, 8'hFF},
    '{BAL_WORD_ADD_IMMEDIATE,            8'hFF, 8'h00, 8'h00, 8'h7F, 6'h01, 8'h00},
    '{BAL_WORD_SUBTRACT_IMMEDIATE,       8'h00, 8'h00, 8'h00, 8'h00, 6'h3F, 8'hC1}
  };

  bal_byte_arith_logic_unit dut (
    .clock         (clock),
    .reset         (reset),
    .op_start      (op_start),
    .op_code       (op_code),
    .dest_reg      (dest_reg),
    .source_reg    (source_reg),
    .imm_value     (imm_value),
    .pair_high     (pair_high),
    .word_imm      (word_imm),
    .result_r      (result_r),
    .result_high_r (result_high_r),
    .done_r        (done_r),
    .busy_r        (busy_r),
    .flag_c_r      (flag_c_r),
    .flag_z_r      (flag_z_r),
    .flag_n_r      (flag_n_r),
    .flag_v_r      (flag_v_r),
    .flag_s_r      (flag_s_r),
    .flag_h_r      (flag_h_r)
  );

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // reference model of result and flags {c z n v s h}
  task automatic predict(input bal_row_t r);
    logic [8:0]  t;
    logic [15:0] w;
    logic [7:0]  x;
    logic [7:0]  y;
    logic        c, z, n, v, s, h, wd, sb;
    {c, z, n, v, s, h} = exp_f;
    x = r.d;
    y = r.s;
    t = 9'h000;
    wd = (r.op == BAL_WORD_ADD_IMMEDIATE);
    sb = (r.op == BAL_WORD_SUBTRACT_IMMEDIATE);
    if (r.op != BAL_FILL_ALL_ONES)
      v = 1'b0;
    case (r.op)
      BAL_ADD, BAL_ADD_CARRY:
      begin
        t = {1'b0, x} + {1'b0, y} + {8'h00, (r.op == BAL_ADD_CARRY) & c};
        h = x[3] & y[3] | y[3] & ~t[3] | ~t[3] & x[3];
        v = x[7] & y[7] & ~t[7] | ~x[7] & ~y[7] & t[7];
        c = t[8];
      end
      BAL_SUBTRACT, BAL_SUBTRACT_CONSTANT, BAL_SUBTRACT_WITH_BORROW,
      BAL_SUBTRACT_CONSTANT_WITH_BORROW, BAL_SIGN_FLIP:
      begin
        if (r.op == BAL_SUBTRACT_CONSTANT ||
            r.op == BAL_SUBTRACT_CONSTANT_WITH_BORROW)
          y = r.k;
        if (r.op == BAL_SIGN_FLIP)
        begin
          x = 8'h00;
          y = r.d;
        end
        t = {1'b0, x} - {1'b0, y} - {8'h00, c &
            (r.op == BAL_SUBTRACT_WITH_BORROW ||
             r.op == BAL_SUBTRACT_CONSTANT_WITH_BORROW)};
        h = ~x[3] & y[3] | y[3] & t[3] | t[3] & ~x[3];
        v = x[7] & ~y[7] & ~t[7] | ~x[7] & y[7] & t[7];
        c = t[8];
      end
      BAL_AND:                t[7:0] = x & y;
      BAL_AND_WITH_CONSTANT:  t[7:0] = x & r.k;
      BAL_OR:                 t[7:0] = x | y;
      BAL_OR_WITH_CONSTANT,
      BAL_SET_BITS_BY_MASK:   t[7:0] = x | r.k;
      BAL_EXCLUSIVE_OR:       t[7:0] = x ^ y;
      BAL_CLEAR_BITS_BY_MASK: t[7:0] = x & (8'hFF - r.k);
      BAL_TEST_ZERO_NEGATIVE: t[7:0] = x;
      BAL_FILL_ALL_ONES:      t[7:0] = 8'hFF;
      BAL_COMPLEMENT:
      begin
        t[7:0] = 8'hFF - x;
        c = 1'b1;
      end
      BAL_PLUS_ONE:
      begin
        t[7:0] = x + 8'h01;
        v = (t[7:0] == 8'h80);
      end
      BAL_MINUS_ONE:
      begin
        t[7:0] = x - 8'h01;
        v = (t[7:0] == 8'h7F);
      end
      default:                t = 9'h000;
    endcase
    if (wd || sb)
    begin
      w = wd ? {r.hi, r.d} + {10'h000, r.w} : {r.hi, r.d} - {10'h000, r.w};
      z = (w == 16'h0000);
      n = w[15];
      v = wd ? ~r.hi[7] & w[15] : r.hi[7] & ~w[15];
      c = wd ? ~w[15] & r.hi[7] : w[15] & ~r.hi[7];
      s = n ^ v;
      {exp_hi, exp_lo} = w;
    end
    else
    begin
      exp_lo = t[7:0];
      if (r.op != BAL_FILL_ALL_ONES)
      begin
        z = (t[7:0] == 8'h00);
        n = t[7];
      end
    end
    exp_f = {c, z, n, v, s, h};
  endtask

  task automatic drive(input bal_row_t r);
    op_start = 1'b1;
    op_code = r.op;
    dest_reg = r.d;
    source_reg = r.s;
    imm_value = r.k;
    pair_high = r.hi;
    word_imm = r.w;
  endtask

  // present at a falling edge, return at the falling edge showing done
  task automatic run_op(input bal_row_t r);
    int  cnt;
    logic wd;
    wd = (r.op == BAL_WORD_ADD_IMMEDIATE ||
          r.op == BAL_WORD_SUBTRACT_IMMEDIATE);
    drive(r);
    predict(r);
    @(negedge clock);
    cnt = 1;
    check({15'h0000, busy_r}, {15'h0000, wd});
    while (done_r !== 1'b1 && cnt < 4)
    begin
      @(negedge clock);
      cnt++;
    end
    if (cnt >= 4)
    begin
      err_count++;
      finish_test;
    end
    check(cnt[15:0], wd ? 16'h0002 : 16'h0001);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    op_start = 1'b0;
    op_code = BAL_ADD;
    dest_reg = 8'h00;
    source_reg = 8'h00;
    imm_value = 8'h00;
    pair_high = 8'h00;
    word_imm = 6'h00;
    err_count = 0;
    samples_checked = 0;
    exp_lo = 8'h00;
    exp_hi = 8'h00;
    exp_f = 6'h00;
    repeat (4) @(negedge clock);
    reset = 1'b0;
    check({result_high_r, result_r}, 16'h0000);
    check({8'h00, done_r, busy_r, flags}, 16'h0000);
    foreach (rows[i])
    begin
      run_op(rows[i]);
      check({8'h00, result_r}, {8'h00, rows[i].res});
      check({8'h00, result_r}, {8'h00, exp_lo});
      check({10'h000, flags}, {10'h000, exp_f});
      check({8'h00, result_high_r}, {8'h00, exp_hi});
    end
    $display("table rows done");
    // back to back byte operations
    drive('{BAL_ADD, 8'h01, 8'h01, 8'h00, 8'h00, 6'h00, 8'h02});
    predict('{BAL_ADD, 8'h01, 8'h01, 8'h00, 8'h00, 6'h00, 8'h02});
    @(negedge clock);
    check({7'h00, done_r, result_r}, 16'h0102);
    run_op('{BAL_SUBTRACT, 8'h05, 8'h01, 8'h00, 8'h00, 6'h00, 8'h04});
    check({7'h00, done_r, result_r}, 16'h0104);
    check({10'h000, flags}, {10'h000, exp_f});
    op_start = 1'b0;
    @(negedge clock);
    check({7'h00, done_r, result_r}, 16'h0004);
    $display("back to back done");
    // request during the word second cycle is ignored
    drive('{BAL_WORD_ADD_IMMEDIATE, 8'h34, 8'h00, 8'h00, 8'h12, 6'h3F, 8'h73});
    predict('{BAL_WORD_ADD_IMMEDIATE, 8'h34, 8'h00, 8'h00, 8'h12, 6'h3F, 8'h73});
    @(negedge clock);
    drive('{BAL_CLEAR_REGISTER, 8'h55, 8'h00, 8'h00, 8'h00, 6'h00, 8'h00});
    check({14'h0000, busy_r, done_r}, 16'h0002);
    @(negedge clock);
    op_start = 1'b0;
    check({7'h00, done_r, result_r}, 16'h0173);
    check({result_high_r, result_r}, 16'h1273);
    check({10'h000, flags}, {10'h000, exp_f});
    @(negedge clock);
    check({7'h00, done_r, result_r}, 16'h0073);
    $display("word refusal done");
    // asynchronous reset in mid-run
    run_op('{BAL_FILL_ALL_ONES, 8'h00, 8'h00, 8'h00, 8'h00, 6'h00, 8'hFF});
    #1;
    reset = 1'b1;
    #1;
    check({result_high_r, result_r}, 16'h0000);
    check({8'h00, done_r, busy_r, flags}, 16'h0000);
    @(negedge clock);
    @(negedge clock);
    reset = 1'b0;
    exp_f = 6'h00;
    run_op('{BAL_ADD_CARRY, 8'hFF, 8'h00, 8'h00, 8'h00, 6'h00, 8'hFF});
    check({8'h00, result_r}, 16'h00FF);
    check({10'h000, flags}, {10'h000, exp_f});
    $display("reset test done");
    finish_test;
  end

endmodule

`default_nettype wire
